// >>> spg_pkg.sv
/*
 * Shared constants and carrier types for the general-purpose ports C, D and E.
 * Assumes a byte-wide register port with one-cycle registered read data.
 */
package spg_pkg;

    localparam int SPG_ADDR_W = 8;
    localparam int SPG_DATA_W = 8;

    localparam logic [7:0] SPG_OFS_PORT_C_LATCH = 8'h02;
    localparam logic [7:0] SPG_OFS_PORT_D_LATCH = 8'h03;
    localparam logic [7:0] SPG_OFS_PORT_C_DIR = 8'h06;
    localparam logic [7:0] SPG_OFS_PORT_D_DIR = 8'h07;
    localparam logic [7:0] SPG_OFS_PORT_E_LATCH = 8'h08;
    localparam logic [7:0] SPG_OFS_PORT_E_DIR = 8'h0C;

    localparam logic [7:0] SPG_DIR_RESET = 8'h00;
    localparam logic [7:0] SPG_PORT_C_MASK = 8'h3F;
    localparam logic [7:0] SPG_PORT_C_DIR_MASK = 8'hBF;
    localparam logic [7:0] SPG_READ_IDLE = 8'h00;

    localparam int SPG_C_CLKOUT_ENABLE_BIT = 7;
    localparam int SPG_C_CLKOUT_PIN = 2;
    localparam int SPG_D_TIMER_A_CLK_PIN = 6;
    localparam int SPG_D_TIMER_B_CLK_PIN = 4;
    localparam int SPG_E_SPI_SCK_PIN = 7;
    localparam int SPG_E_SPI_MOSI_PIN = 6;
    localparam int SPG_E_SPI_MISO_PIN = 5;
    localparam int SPG_E_SPI_SS_PIN = 4;
    localparam int SPG_E_TIMER_CH1_PIN = 3;
    localparam int SPG_E_TIMER_CH0_PIN = 2;
    localparam int SPG_E_SCI_RX_PIN = 1;
    localparam int SPG_E_SCI_TX_PIN = 0;

    localparam int SPG_SYNC_STAGES = 2;

    // Drive side of one 8-pin port: level and output enable per pin.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } spg_pad_drive_t;

    // Register port request.
    typedef struct packed {
        logic [SPG_ADDR_W-1:0] addr;
        logic [SPG_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } spg_reg_req_t;

endpackage : spg_pkg

// >>> spg_sync.sv
/*
 * Two-stage synchroniser for a bus of asynchronous pin levels.
 * Assumes the inputs are levels that may change at any time.
 */
`timescale 1ns/1ps
module spg_sync
    import spg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk_in) begin
        meta_q <= async_in;
        sync_out <= meta_q;
    end

endmodule : spg_sync

// >>> spg_port_mux.sv
/*
 * Per-port pin steering: chooses between latch and peripheral for each pin
 * and forms the value that a read of the data register returns.
 * Assumes all inputs are on the bus clock and pin levels are synchronised.
 */
`timescale 1ns/1ps
module spg_port_mux
    import spg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] latch_in,
    input wire logic [WIDTH-1:0] dir_in,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] own_in,
    input wire logic [WIDTH-1:0] periph_out_in,
    input wire logic [WIDTH-1:0] periph_oe_in,
    input wire logic [WIDTH-1:0] read_zero_in,
    output logic [WIDTH-1:0] pad_out_out,
    output logic [WIDTH-1:0] pad_oe_out,
    output logic [WIDTH-1:0] read_out
);

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            // An owned pin ignores its direction bit for driving.
            pad_oe_out[i] = own_in[i] ? periph_oe_in[i] : dir_in[i];
            pad_out_out[i] = own_in[i] ? periph_out_in[i] : latch_in[i];
            // Direction still chooses latch or pin on reads; read_zero_in gives zero in place of the pin.
            if (dir_in[i]) begin
                read_out[i] = latch_in[i];
            end else if (read_zero_in[i]) begin
                read_out[i] = 1'b0;
            end else begin
                read_out[i] = pin_in[i];
            end
        end
    end

endmodule : spg_port_mux

// >>> spg_gpio_cde.sv
/*
 * General-purpose ports C (6 pins), D and E (8 pins each), with the clock
 * output on port C pin 2 and pin sharing with timers, SPI and SCI.
 * Assumes a plain register port on ref_clk_in and peripheral controls on the
 * same clock; pin levels arrive asynchronously and are synchronised here.
 */
//  Function
//  - Port C latches hold value through reset.
//  - Port C direction one drives, zero floats.
//  - Reset clears port C direction and clock-out.
//  - Clock-out enable drives system clock on pin 2.
//  - Clock-out owns pin 2; reads zero, writes ignored.
//  - Port C reads latch if output, else pin.
//  - Port D eight latches, direction drives buffers.
//  - Reset clears all port D direction bits.
//  - Port D reads latch or pin; always writable.
//  - Timer pins on D: direction selects latch or zero.
//  - D6, D4 become timer clocks when selected.
//  - E7 is SPI clock, direction from master bit.
//  - E6 master-out, E5 master-in while SPI enabled.
//  - E4 slave select only as enabled slave.
//  - SPI-owned E pins: direction only steers reads.
//  - E3, E2 become timer channels when selected.
//  - E1 receive, E0 transmit while SCI enabled.
//  - Port E latches drive unowned output pins.
`timescale 1ns/1ps
module spg_gpio_cde
    import spg_pkg::*;
#(
    parameter logic [2:0] EXT_CLK_SELECT = 3'h7
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire spg_reg_req_t reg_req_in,
    output logic [SPG_DATA_W-1:0] reg_rdata_out,
    input wire logic [7:0] port_c_pin_in,
    output spg_pad_drive_t port_c_pad_out,
    input wire logic [7:0] port_d_pin_in,
    output spg_pad_drive_t port_d_pad_out,
    input wire logic [7:0] port_e_pin_in,
    output spg_pad_drive_t port_e_pad_out,
    input wire logic [2:0] timer_a_prescaler_select_in,
    input wire logic [2:0] timer_b_prescaler_select_in,
    input wire logic [1:0] timer_a_ch0_edge_level_select_in,
    input wire logic [1:0] timer_a_ch1_edge_level_select_in,
    input wire logic [1:0] timer_a_channel_pins_out_in,
    input wire logic [1:0] timer_a_channel_pins_oe_in,
    input wire logic spi_enable_bit_in,
    input wire logic spi_master_bit_in,
    input wire logic spi_serial_clock_drive_in,
    input wire logic spi_mosi_drive_in,
    input wire logic spi_miso_drive_in,
    input wire logic sci_enable_bit_in,
    input wire logic sci_tx_drive_in,
    output logic timer_a_ext_clock_out,
    output logic timer_b_ext_clock_out,
    output logic [1:0] timer_a_channel_pins_level_out,
    output logic spi_serial_clock_level_out,
    output logic spi_mosi_level_out,
    output logic spi_miso_level_out,
    output logic spi_slave_select_level_out,
    output logic sci_rx_level_out
);

    logic [7:0] port_c_latch_q;
    logic [7:0] port_d_latch_q;
    logic [7:0] port_e_latch_q;
    logic [7:0] port_c_dir_q;
    logic [7:0] port_d_dir_q;
    logic [7:0] port_e_dir_q;
    logic clock_out_q;
    logic [7:0] pin_c_s;
    logic [7:0] pin_d_s;
    logic [7:0] pin_e_s;
    logic clock_out_enable;
    logic timer_a_clk_sel;
    logic timer_b_clk_sel;
    logic spi_slave;
    logic [7:0] own_c;
    logic [7:0] own_d;
    logic [7:0] own_e;
    logic [7:0] per_out_c;
    logic [7:0] per_oe_c;
    logic [7:0] per_out_e;
    logic [7:0] per_oe_e;
    logic [7:0] drv_out_c;
    logic [7:0] drv_oe_c;
    logic [7:0] drv_out_d;
    logic [7:0] drv_oe_d;
    logic [7:0] drv_out_e;
    logic [7:0] drv_oe_e;
    logic [7:0] rd_c;
    logic [7:0] rd_d;
    logic [7:0] rd_e;
    logic [7:0] rdata_d;

    spg_sync #(.WIDTH(8)) u_sync_c (
        .ref_clk_in(ref_clk_in),
        .async_in(port_c_pin_in),
        .sync_out(pin_c_s)
    );

    spg_sync #(.WIDTH(8)) u_sync_d (
        .ref_clk_in(ref_clk_in),
        .async_in(port_d_pin_in),
        .sync_out(pin_d_s)
    );

    spg_sync #(.WIDTH(8)) u_sync_e (
        .ref_clk_in(ref_clk_in),
        .async_in(port_e_pin_in),
        .sync_out(pin_e_s)
    );

    // Ownership of shared pins.
    assign clock_out_enable = port_c_dir_q[SPG_C_CLKOUT_ENABLE_BIT];
    assign timer_a_clk_sel = (timer_a_prescaler_select_in == EXT_CLK_SELECT);
    assign timer_b_clk_sel = (timer_b_prescaler_select_in == EXT_CLK_SELECT);
    assign spi_slave = spi_enable_bit_in & ~spi_master_bit_in;

    always_comb begin
        own_c = 8'h00;
        per_out_c = 8'h00;
        per_oe_c = 8'h00;
        own_c[SPG_C_CLKOUT_PIN] = clock_out_enable;
        per_out_c[SPG_C_CLKOUT_PIN] = clock_out_q;
        per_oe_c[SPG_C_CLKOUT_PIN] = 1'b1;
    end

    always_comb begin
        own_d = 8'h00;
        own_d[SPG_D_TIMER_A_CLK_PIN] = timer_a_clk_sel;
        own_d[SPG_D_TIMER_B_CLK_PIN] = timer_b_clk_sel;
    end

    always_comb begin
        own_e = 8'h00;
        per_out_e = 8'h00;
        per_oe_e = 8'h00;
        own_e[SPG_E_SPI_SCK_PIN] = spi_enable_bit_in;
        per_out_e[SPG_E_SPI_SCK_PIN] = spi_serial_clock_drive_in;
        per_oe_e[SPG_E_SPI_SCK_PIN] = spi_master_bit_in;
        own_e[SPG_E_SPI_MOSI_PIN] = spi_enable_bit_in;
        per_out_e[SPG_E_SPI_MOSI_PIN] = spi_mosi_drive_in;
        per_oe_e[SPG_E_SPI_MOSI_PIN] = spi_master_bit_in;
        own_e[SPG_E_SPI_MISO_PIN] = spi_enable_bit_in;
        per_out_e[SPG_E_SPI_MISO_PIN] = spi_miso_drive_in;
        per_oe_e[SPG_E_SPI_MISO_PIN] = ~spi_master_bit_in;
        own_e[SPG_E_SPI_SS_PIN] = spi_slave;
        own_e[SPG_E_TIMER_CH1_PIN] = |timer_a_ch1_edge_level_select_in;
        per_out_e[SPG_E_TIMER_CH1_PIN] = timer_a_channel_pins_out_in[1];
        per_oe_e[SPG_E_TIMER_CH1_PIN] = timer_a_channel_pins_oe_in[1];
        own_e[SPG_E_TIMER_CH0_PIN] = |timer_a_ch0_edge_level_select_in;
        per_out_e[SPG_E_TIMER_CH0_PIN] = timer_a_channel_pins_out_in[0];
        per_oe_e[SPG_E_TIMER_CH0_PIN] = timer_a_channel_pins_oe_in[0];
        own_e[SPG_E_SCI_RX_PIN] = sci_enable_bit_in;
        own_e[SPG_E_SCI_TX_PIN] = sci_enable_bit_in;
        per_out_e[SPG_E_SCI_TX_PIN] = sci_tx_drive_in;
        per_oe_e[SPG_E_SCI_TX_PIN] = 1'b1;
    end

    spg_port_mux #(.WIDTH(8)) u_mux_c (
        .latch_in(port_c_latch_q),
        .dir_in(port_c_dir_q & SPG_PORT_C_MASK),
        .pin_in(pin_c_s),
        .own_in(own_c),
        .periph_out_in(per_out_c),
        .periph_oe_in(per_oe_c),
        .read_zero_in(8'h00),
        .pad_out_out(drv_out_c),
        .pad_oe_out(drv_oe_c),
        .read_out(rd_c)
    );

    spg_port_mux #(.WIDTH(8)) u_mux_d (
        .latch_in(port_d_latch_q),
        .dir_in(port_d_dir_q),
        .pin_in(pin_d_s),
        .own_in(own_d),
        .periph_out_in(8'h00),
        .periph_oe_in(8'h00),
        .read_zero_in(own_d),
        .pad_out_out(drv_out_d),
        .pad_oe_out(drv_oe_d),
        .read_out(rd_d)
    );

    spg_port_mux #(.WIDTH(8)) u_mux_e (
        .latch_in(port_e_latch_q),
        .dir_in(port_e_dir_q),
        .pin_in(pin_e_s),
        .own_in(own_e),
        .periph_out_in(per_out_e),
        .periph_oe_in(per_oe_e),
        .read_zero_in(8'h00),
        .pad_out_out(drv_out_e),
        .pad_oe_out(drv_oe_e),
        .read_out(rd_e)
    );

    // Data latches carry no reset.
    always_ff @(posedge ref_clk_in) begin
        if (reg_req_in.wr && reg_req_in.addr == SPG_OFS_PORT_C_LATCH) begin
            port_c_latch_q[7:3] <= reg_req_in.wdata[7:3] & SPG_PORT_C_MASK[7:3];
            port_c_latch_q[1:0] <= reg_req_in.wdata[1:0];
            if (!clock_out_enable) begin
                port_c_latch_q[SPG_C_CLKOUT_PIN] <= reg_req_in.wdata[SPG_C_CLKOUT_PIN];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reg_req_in.wr && reg_req_in.addr == SPG_OFS_PORT_D_LATCH) begin
            port_d_latch_q <= reg_req_in.wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reg_req_in.wr && reg_req_in.addr == SPG_OFS_PORT_E_LATCH) begin
            port_e_latch_q <= reg_req_in.wdata;
        end
    end

    // Direction registers clear on reset.
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            port_c_dir_q <= SPG_DIR_RESET;
        end else if (reg_req_in.wr && reg_req_in.addr == SPG_OFS_PORT_C_DIR) begin
            port_c_dir_q <= reg_req_in.wdata & SPG_PORT_C_DIR_MASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            port_d_dir_q <= SPG_DIR_RESET;
        end else if (reg_req_in.wr && reg_req_in.addr == SPG_OFS_PORT_D_DIR) begin
            port_d_dir_q <= reg_req_in.wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            port_e_dir_q <= SPG_DIR_RESET;
        end else if (reg_req_in.wr && reg_req_in.addr == SPG_OFS_PORT_E_DIR) begin
            port_e_dir_q <= reg_req_in.wdata;
        end
    end

    // Bus clock image: toggles every cycle while the output is enabled.
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in || !clock_out_enable) begin
            clock_out_q <= 1'b0;
        end else begin
            clock_out_q <= ~clock_out_q;
        end
    end

    // Pad drive registers.
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            port_c_pad_out <= '0;
            port_d_pad_out <= '0;
            port_e_pad_out <= '0;
        end else begin
            port_c_pad_out.out <= drv_out_c & SPG_PORT_C_MASK;
            port_c_pad_out.oe <= drv_oe_c & SPG_PORT_C_MASK;
            port_d_pad_out.out <= drv_out_d;
            port_d_pad_out.oe <= drv_oe_d;
            port_e_pad_out.out <= drv_out_e;
            port_e_pad_out.oe <= drv_oe_e;
        end
    end

    // Synchronised levels handed to the peripherals.
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            timer_a_ext_clock_out <= 1'b0;
            timer_b_ext_clock_out <= 1'b0;
            timer_a_channel_pins_level_out <= 2'h0;
            spi_serial_clock_level_out <= 1'b0;
            spi_mosi_level_out <= 1'b0;
            spi_miso_level_out <= 1'b0;
            spi_slave_select_level_out <= 1'b1;
            sci_rx_level_out <= 1'b1;
        end else begin
            timer_a_ext_clock_out <= timer_a_clk_sel & pin_d_s[SPG_D_TIMER_A_CLK_PIN];
            timer_b_ext_clock_out <= timer_b_clk_sel & pin_d_s[SPG_D_TIMER_B_CLK_PIN];
            timer_a_channel_pins_level_out <= pin_e_s[SPG_E_TIMER_CH1_PIN:SPG_E_TIMER_CH0_PIN];
            spi_serial_clock_level_out <= pin_e_s[SPG_E_SPI_SCK_PIN];
            spi_mosi_level_out <= pin_e_s[SPG_E_SPI_MOSI_PIN];
            spi_miso_level_out <= pin_e_s[SPG_E_SPI_MISO_PIN];
            spi_slave_select_level_out <= pin_e_s[SPG_E_SPI_SS_PIN] | ~spi_slave;
            sci_rx_level_out <= pin_e_s[SPG_E_SCI_RX_PIN] | ~sci_enable_bit_in;
        end
    end

    // Read decode; unmapped offsets read zero.
    always_comb begin
        rdata_d = SPG_READ_IDLE;
        unique case (reg_req_in.addr)
            SPG_OFS_PORT_C_LATCH: begin
                rdata_d = rd_c & SPG_PORT_C_MASK;
                if (clock_out_enable) begin
                    rdata_d[SPG_C_CLKOUT_PIN] = 1'b0;
                end
            end
            SPG_OFS_PORT_D_LATCH: rdata_d = rd_d;
            SPG_OFS_PORT_C_DIR: rdata_d = port_c_dir_q;
            SPG_OFS_PORT_D_DIR: rdata_d = port_d_dir_q;
            SPG_OFS_PORT_E_LATCH: rdata_d = rd_e;
            SPG_OFS_PORT_E_DIR: rdata_d = port_e_dir_q;
            default: rdata_d = SPG_READ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in || !reg_req_in.rd) begin
            reg_rdata_out <= SPG_READ_IDLE;
        end else begin
            reg_rdata_out <= rdata_d;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_latch_hold;
        @(posedge ref_clk_in) disable iff (1'b0)
        (!reset_n_in && !reg_req_in.wr) |=> $stable(port_c_latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Port C latch changed in reset.");

    property p_c_oe;
        !clock_out_enable |=> port_c_pad_out.oe == ($past(port_c_dir_q) & SPG_PORT_C_MASK);
    endproperty
    a_c_oe: assert property (p_c_oe) else $error("Port C enable does not follow direction.");

    property p_c_dir_reset;
        @(posedge ref_clk_in) disable iff (1'b0)
        !reset_n_in |=> port_c_dir_q == SPG_DIR_RESET && !port_c_pad_out.oe[2];
    endproperty
    a_c_dir_reset: assert property (p_c_dir_reset) else $error("Port C direction not cleared.");

    property p_clock_out;
        clock_out_enable [*2] |=> port_c_pad_out.oe[2]
            && port_c_pad_out.out[2] != $past(port_c_pad_out.out[2]);
    endproperty
    a_clock_out: assert property (p_clock_out) else $error("Clock output not driven on pin 2.");

    property p_c2_read_zero;
        (reg_req_in.rd && reg_req_in.addr == SPG_OFS_PORT_C_LATCH && clock_out_enable)
            |=> !reg_rdata_out[2];
    endproperty
    a_c2_read_zero: assert property (p_c2_read_zero) else $error("Pin 2 read not zero.");

    property p_c_read_latch;
        (reg_req_in.rd && reg_req_in.addr == SPG_OFS_PORT_C_LATCH && !clock_out_enable
            && port_c_dir_q[5:0] == 6'h3F) |=> reg_rdata_out == $past(port_c_latch_q & SPG_PORT_C_MASK);
    endproperty
    a_c_read_latch: assert property (p_c_read_latch) else $error("Port C read not latch.");

    property p_d_dir_reset;
        @(posedge ref_clk_in) disable iff (1'b0)
        !reset_n_in |=> port_d_dir_q == SPG_DIR_RESET;
    endproperty
    a_d_dir_reset: assert property (p_d_dir_reset) else $error("Port D direction not cleared.");

    property p_d_timer_read;
        (reg_req_in.rd && reg_req_in.addr == SPG_OFS_PORT_D_LATCH && timer_a_clk_sel
            && !port_d_dir_q[6]) |=> !reg_rdata_out[6];
    endproperty
    a_d_timer_read: assert property (p_d_timer_read) else $error("Timer pin read not zero.");

    property p_d_timer_input;
        timer_b_clk_sel |=> !port_d_pad_out.oe[4];
    endproperty
    a_d_timer_input: assert property (p_d_timer_input) else $error("Timer clock pin driven.");

    property p_spi_ss;
        spi_slave |=> !port_e_pad_out.oe[4];
    endproperty
    a_spi_ss: assert property (p_spi_ss) else $error("Slave select pin driven.");

    property p_sci_pins;
        sci_enable_bit_in |=> !port_e_pad_out.oe[1] && port_e_pad_out.oe[0];
    endproperty
    a_sci_pins: assert property (p_sci_pins) else $error("SCI pin direction wrong.");

    property p_e_gpio;
        own_e == 8'h00 |=> port_e_pad_out.oe == $past(port_e_dir_q)
            && port_e_pad_out.out == $past(port_e_latch_q);
    endproperty
    a_e_gpio: assert property (p_e_gpio) else $error("Port E latch not driving.");

    property p_c_dir6;
        port_c_dir_q[6] == 1'b0;
    endproperty
    a_c_dir6: assert property (p_c_dir6) else $error("Direction C bit 6 set.");

    c_clock_out: cover property (clock_out_enable ##3 clock_out_enable);
    c_spi_master: cover property (spi_enable_bit_in && spi_master_bit_in);
    c_read_pin: cover property (reg_req_in.rd && reg_req_in.addr == SPG_OFS_PORT_E_LATCH
        && port_e_dir_q == 8'h00);

endmodule : spg_gpio_cde

// >>> spg_pin_model.sv
/*
 * Board model for one port: each pin follows the device while it drives it.
 * Assumes the testbench supplies the board level of every released pin.
 */
`timescale 1ns/1ps
module spg_pin_model
    import spg_pkg::*;
(
    input wire spg_pad_drive_t pad_in,
    input wire logic [7:0] board_in,
    output logic [7:0] pin_out
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_out[i] = pad_in.oe[i] ? pad_in.out[i] : board_in[i];
        end
    end
endmodule : spg_pin_model

// >>> tb_top.sv
/*
 * Self-checking bench for ports C, D and E.
 * Assumes the board model drives released pins with the board levels.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t bad value", $time); end end
module tb_top
    import spg_pkg::*;
;
    logic clk = 0;
    logic rst_n = 0;
    spg_reg_req_t req = '0;
    logic [7:0] rdata, pin_c, pin_d, pin_e;
    logic [7:0] bc = 0, bd = 0, be = 8'h80;
    spg_pad_drive_t pc, pd, pe;
    logic [2:0] psa = 0, psb = 0;
    logic [1:0] el0 = 0, el1 = 0, tco = 0, toe = 0, tcl;
    logic spi_enable_bit = 0, spm = 0, sck = 0, mosi = 0, miso = 0, sce = 0, tx = 0;
    logic tacl, tbcl, sckl, mosil, misol, ssl, rxl, b;
    int error_cnt = 0;
    int num_checks = 0;

    always #2 clk = ~clk;

    spg_gpio_cde i_spg_gpio_cde (.ref_clk_in(clk), .reset_n_in(rst_n), .reg_req_in(req),
        .reg_rdata_out(rdata), .port_c_pin_in(pin_c), .port_c_pad_out(pc),
        .port_d_pin_in(pin_d), .port_d_pad_out(pd), .port_e_pin_in(pin_e),
        .port_e_pad_out(pe), .timer_a_prescaler_select_in(psa),
        .timer_b_prescaler_select_in(psb), .timer_a_ch0_edge_level_select_in(el0),
        .timer_a_ch1_edge_level_select_in(el1), .timer_a_channel_pins_out_in(tco),
        .timer_a_channel_pins_oe_in(toe), .spi_enable_bit_in(spi_enable_bit), .spi_master_bit_in(spm),
        .spi_serial_clock_drive_in(sck), .spi_mosi_drive_in(mosi), .spi_miso_drive_in(miso),
        .sci_enable_bit_in(sce), .sci_tx_drive_in(tx), .timer_a_ext_clock_out(tacl),
        .timer_b_ext_clock_out(tbcl), .timer_a_channel_pins_level_out(tcl),
        .spi_serial_clock_level_out(sckl), .spi_mosi_level_out(mosil),
        .spi_miso_level_out(misol), .spi_slave_select_level_out(ssl), .sci_rx_level_out(rxl));
    spg_pin_model i_spg_pin_model_c (.pad_in(pc), .board_in(bc), .pin_out(pin_c));
    spg_pin_model i_spg_pin_model_d (.pad_in(pd), .board_in(bd), .pin_out(pin_d));
    spg_pin_model i_spg_pin_model_e (.pad_in(pe), .board_in(be), .pin_out(pin_e));

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd

    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task t_port_c;
        wr(SPG_OFS_PORT_C_LATCH, 8'h15);
        wr(SPG_OFS_PORT_C_DIR, 8'h3F);
        idle(3);
        `CHK(pc.oe, 8'h3F)
        `CHK(pc.out, 8'h15)
        rd(SPG_OFS_PORT_C_LATCH, 8'h15);
        @(posedge clk) bc <= 8'h2E;
        wr(SPG_OFS_PORT_C_DIR, 8'h0F);
        idle(3);
        rd(SPG_OFS_PORT_C_LATCH, 8'h25);
        wr(SPG_OFS_PORT_C_DIR, 8'hFF);
        idle(3);
        rd(SPG_OFS_PORT_C_DIR, 8'hBF);
        `CHK(pc.oe[2], 1'b1)
        b = pc.out[2];
        idle(1);
        `CHK(pc.out[2], ~b)
        rd(SPG_OFS_PORT_C_LATCH, 8'h11);
        wr(SPG_OFS_PORT_C_DIR, 8'h3B);
        idle(3);
        `CHK(pc.oe, 8'h3B)
        rd(SPG_OFS_PORT_C_LATCH, 8'h15);
    endtask : t_port_c

    task t_port_d;
        wr(SPG_OFS_PORT_D_LATCH, 8'hA5);
        wr(SPG_OFS_PORT_D_DIR, 8'hFF);
        idle(3);
        `CHK(pd.oe, 8'hFF)
        `CHK(pd.out, 8'hA5)
        @(posedge clk) begin
            psa <= 3'h7;
            psb <= 3'h7;
            bd <= 8'h50;
        end
        idle(3);
        `CHK(pd.oe, 8'hAF)
        rd(SPG_OFS_PORT_D_LATCH, 8'hA5);
        wr(SPG_OFS_PORT_D_DIR, 8'h00);
        idle(3);
        rd(SPG_OFS_PORT_D_LATCH, 8'h00);
        `CHK({tacl, tbcl}, 2'b11)
        @(posedge clk) begin
            psa <= 3'h0;
            psb <= 3'h0;
        end
        idle(3);
        rd(SPG_OFS_PORT_D_LATCH, 8'h50);
        `CHK({tacl, tbcl}, 2'b00)
    endtask : t_port_d

    task t_reset_keep;
        @(posedge clk) rst_n <= 1'b0;
        idle(4);
        @(posedge clk) rst_n <= 1'b1;
        idle(1);
        `CHK(pc.oe, 8'h00)
        rd(SPG_OFS_PORT_C_DIR, 8'h00);
        rd(SPG_OFS_PORT_D_DIR, 8'h00);
        wr(SPG_OFS_PORT_C_DIR, 8'h3F);
        idle(3);
        rd(SPG_OFS_PORT_C_LATCH, 8'h15);
    endtask : t_reset_keep

    task t_port_e;
        wr(SPG_OFS_PORT_E_LATCH, 8'h5A);
        wr(SPG_OFS_PORT_E_DIR, 8'hFF);
        idle(3);
        `CHK(pe.oe, 8'hFF)
        `CHK(pe.out, 8'h5A)
        @(posedge clk) begin
            spi_enable_bit <= 1'b1;
            spm <= 1'b1;
            sck <= 1'b1;
        end
        idle(3);
        `CHK(pe.oe[7:4], 4'b1101)
        `CHK(pe.out[7:6], 2'b10)
        rd(SPG_OFS_PORT_E_LATCH, 8'h5A);
        @(posedge clk) begin
            spm <= 1'b0;
            miso <= 1'b1;
        end
        idle(4);
        `CHK(pe.oe[7:4], 4'b0010)
        `CHK({sckl, ssl}, 2'b10)
        `CHK({mosil, misol}, 2'b01)
        @(posedge clk) begin
            spi_enable_bit <= 1'b0;
            el0 <= 2'b01;
            tco <= 2'b01;
            toe <= 2'b01;
            sce <= 1'b1;
            tx <= 1'b1;
        end
        idle(4);
        `CHK(pe.oe, 8'hFD)
        `CHK({pe.out[2], pe.out[0], rxl}, 3'b110)
        wr(SPG_OFS_PORT_E_DIR, 8'h00);
        idle(3);
        rd(SPG_OFS_PORT_E_LATCH, 8'h85);
        `CHK(tcl, 2'b01)
    endtask : t_port_e

    task end_sim;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        wr(SPG_OFS_PORT_C_LATCH, 8'h00);
        wr(SPG_OFS_PORT_E_LATCH, 8'h00);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_port_c();
        t_port_d();
        t_reset_keep();
        t_port_e();
        end_sim();
    end

    initial begin
        #50000;
        error_cnt++;
        end_sim();
    end
endmodule : tb_top
